/* logic/hspp_pkg.sv */
// shared constants and carrier types for the strap and port power block
package hspp_pkg;

   // configuration sources chosen by the two select straps
   typedef enum logic [2:0]
   {
      HSPP_CFG_SMBUS  = 3'b001,
      HSPP_CFG_STRAP  = 3'b010,
      HSPP_CFG_EEPROM = 3'b100
   } hspp_cfg_e;

   // smbus slave address
   localparam logic [6:0] SMB_SLAVE_ADDR = 7'h2c;

   // strap encodings
   localparam logic [1:0] FIXED_NONE    = 2'h0;
   localparam logic [1:0] FIXED_P1      = 2'h1;
   localparam logic [1:0] FIXED_P1_P2   = 2'h2;
   localparam logic [1:0] FIXED_P1_P2_B = 2'h3;
   localparam logic       POL_ACT_HIGH  = 1'h1;

   // reset values of latched straps: power polarity high means power off at 0
   localparam logic       POL_RST       = 1'h1;
   localparam logic [1:0] FIXED_RST     = 2'h0;

   // synchroniser depth for the over-current input
   localparam int         OC_SYNC_STAGES = 2;

   // straps captured at reset release
   typedef struct packed
   {
      logic       pol;
      logic [1:0] fixed;
      logic       sel1;
      logic       sel0;
   } hspp_strap_s;

   // resolved led configuration
   typedef struct packed
   {
      logic       led2_act_low;
      logic       led1_act_low;
      logic [1:0] non_removable;
   } hspp_ledcfg_s;

endpackage

/* logic/hspp_sync.sv */
// two flop synchroniser for a level
`timescale 1ns/1ps
module hspp_sync
(
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic rst,
   // level in and out
   input  wire logic in_level,
   input  wire logic rst_val,
   output logic      out_level
);
   logic [1:0] sync_q;
   logic [1:0] sync_d;

   always_comb
   begin
      sync_d = {sync_q[0], in_level};
   end

   // async reset loads a constant; the output xor with rst_val makes it read rst_val during reset
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         sync_q <= 2'h3;
      end
      else
      begin
         sync_q <= sync_d;
      end
   end

   assign out_level = sync_q[1] ^ ~rst_val;
endmodule

/* logic/hspp_port_power.sv */
// strap capture, configuration select and ganged port power control
`timescale 1ns/1ps
//
// Contract
// - one port power enable output, active level from the polarity strap
// - in reset, enable follows polarity strap combinationally, power off
// - polarity strap latched at reset release, kept until next reset
// - latched one means active high, zero means active low
// - led support from eeprom or smbus drives both green leds active low
// - strap defaults sample the fixed port strap at reset release
// - strap 00: all ports removable, both leds active high
// - strap 01: port one fixed, led two high, led one low
// - strap 10: ports one and two fixed, led two low, led one high
// - strap 11: ports one and two fixed, both leds active low
// - select bit zero pin read at reset release
// - select bit one read at reset release, combined with bit zero
// - one serial data pin shared by eeprom and smbus roles
// - select bit one low means smbus slave at address 0101100
// - 1,0 selects strap defaults; 1,1 selects eeprom load
module hspp_port_power
(
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 rst,
   // strap pins
   input  wire logic                 power_polarity_strap,
   input  wire logic [1:0]           fixed_port_strap,
   input  wire logic                 config_select_bit1,
   // serial clock pin, doubles as select bit zero strap
   input  wire logic                 sm_serial_clock_in,
   // serial data pin, shared by eeprom master and smbus slave
   input  wire logic                 sm_serial_data_in,
   output logic                      sm_serial_data_out,
   output logic                      sm_serial_data_oe,
   // serial engine side of the shared data pin
   input  wire logic                 engine_data_drive_low,
   output logic                      engine_data_in,
   // power switch
   input  wire logic                 overcurrent_sense_low,
   output logic                      port_power_enable,
   // hub engine requests
   input  wire logic                 power_request,
   input  wire logic                 led_led_on_req_unused,
   input  wire logic [1:0]           led_on,
   input  wire logic                 led_support_cfg,
   // leds
   output logic [1:0]                green_led_outputs,
   // status
   output hspp_pkg::hspp_cfg_e       config_source,
   output logic [6:0]                smbus_slave_addr,
   output logic [1:0]                non_removable,
   output logic                      overcurrent_active
);
   hspp_pkg::hspp_strap_s  strap_q;
   hspp_pkg::hspp_strap_s  strap_d;
   logic                   armed_q;
   logic                   armed_d;
   hspp_pkg::hspp_ledcfg_s ledcfg;
   hspp_pkg::hspp_cfg_e    cfg_src;
   logic                   oc_low_sync;
   logic                   pol_run;
   logic                   power_on;
   logic [1:0]             led_act_low;
   logic [1:0]             led_q;
   logic [1:0]             led_d;

   // capture straps on the first clock after reset release; a strap may not
   // be loaded by the async reset itself, so it is caught here
   always_comb
   begin
      armed_d = 1'h1;
      strap_d = strap_q;
      if (!armed_q)
      begin
         strap_d.pol   = power_polarity_strap;
         strap_d.fixed = fixed_port_strap;
         strap_d.sel0  = sm_serial_clock_in;
         strap_d.sel1  = config_select_bit1;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         armed_q <= 1'h0;
         strap_q <= '{pol: hspp_pkg::POL_RST, fixed: hspp_pkg::FIXED_RST,
                      sel1: 1'h1, sel0: 1'h0};
      end
      else
      begin
         armed_q <= armed_d;
         strap_q <= strap_d;
      end
   end

   // configuration source
   always_comb
   begin
      if (!strap_q.sel1)
      begin
         cfg_src = hspp_pkg::HSPP_CFG_SMBUS;
      end
      else if (!strap_q.sel0)
      begin
         cfg_src = hspp_pkg::HSPP_CFG_STRAP;
      end
      else
      begin
         cfg_src = hspp_pkg::HSPP_CFG_EEPROM;
      end
   end

   // led polarity and fixed ports
   always_comb
   begin
      ledcfg = '0;
      if (cfg_src != hspp_pkg::HSPP_CFG_STRAP)
      begin
         ledcfg.led2_act_low = led_support_cfg;
         ledcfg.led1_act_low = led_support_cfg;
      end
      else
      begin
         unique case (strap_q.fixed)
            hspp_pkg::FIXED_NONE:
            begin
               ledcfg = '{1'h0, 1'h0, 2'h0};
            end
            hspp_pkg::FIXED_P1:
            begin
               ledcfg = '{1'h0, 1'h1, 2'h1};
            end
            hspp_pkg::FIXED_P1_P2:
            begin
               ledcfg = '{1'h1, 1'h0, 2'h3};
            end
            hspp_pkg::FIXED_P1_P2_B:
            begin
               ledcfg = '{1'h1, 1'h1, 2'h3};
            end
         endcase
      end
   end

   assign led_act_low = {ledcfg.led2_act_low, ledcfg.led1_act_low};

   always_comb
   begin
      led_d = led_on ^ led_act_low;
      if (!armed_q)
      begin
         led_d = led_act_low;
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         led_q <= 2'h0;
      end
      else
      begin
         led_q <= led_d;
      end
   end

   // over-current, low active from the switch; reset value keeps it idle
   hspp_sync u_oc_sync
   (
      .ref_clk   (ref_clk),
      .rst       (rst),
      .in_level  (overcurrent_sense_low),
      .rst_val   (1'h1),
      .out_level (oc_low_sync)
   );

   // live polarity: raw strap during reset and before capture
   assign pol_run  = (rst || !armed_q) ? power_polarity_strap : strap_q.pol;
   assign power_on = power_request && oc_low_sync && armed_q && !rst;

   // level follows polarity; active high when one, active low when zero
   assign port_power_enable = (pol_run == hspp_pkg::POL_ACT_HIGH) ?
                              power_on : !power_on;

   // shared data pin: open drain, engine pulls low only
   assign sm_serial_data_out = 1'h0;
   assign sm_serial_data_oe  = engine_data_drive_low && armed_q;
   assign engine_data_in     = sm_serial_data_in;

   assign green_led_outputs  = led_q;
   assign config_source      = cfg_src;
   assign smbus_slave_addr   = hspp_pkg::SMB_SLAVE_ADDR;
   assign non_removable      = ledcfg.non_removable;
   assign overcurrent_active = !oc_low_sync;

   // assertions
   pwr_reset_off_a: assert property (@(posedge ref_clk)
      !armed_q |-> port_power_enable == !power_polarity_strap)
      else $error("power enable not inactive before strap capture");

   pol_hold_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      armed_q && $past(armed_q) |-> $stable(strap_q.pol))
      else $error("latched polarity changed");

   pol_level_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      armed_q && power_on |-> port_power_enable == strap_q.pol)
      else $error("power enable level wrong for polarity");

   oc_off_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      !overcurrent_sense_low ##1 !overcurrent_sense_low ##1
      !overcurrent_sense_low |-> port_power_enable == !strap_q.pol)
      else $error("power stays on during over-current");

   smbus_src_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      armed_q && !strap_q.sel1 |-> cfg_src == hspp_pkg::HSPP_CFG_SMBUS)
      else $error("select one low did not give smbus");

   eeprom_src_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      strap_q.sel1 && strap_q.sel0 |-> cfg_src == hspp_pkg::HSPP_CFG_EEPROM)
      else $error("select 11 did not give eeprom");

   led_cfg_low_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      armed_q && cfg_src != hspp_pkg::HSPP_CFG_STRAP && led_support_cfg
      |=> green_led_outputs == ~$past(led_on))
      else $error("configured leds not active low");

   led_strap_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      armed_q && cfg_src == hspp_pkg::HSPP_CFG_STRAP
      && strap_q.fixed == hspp_pkg::FIXED_P1
      |-> led_act_low == 2'h1 && non_removable == 2'h1)
      else $error("strap 01 led or fixed port wrong");

   capture_a: assert property (@(posedge ref_clk)
      disable iff (rst)
      !armed_q |=> strap_q.fixed == $past(fixed_port_strap)
      && strap_q.sel1 == $past(config_select_bit1)
      && strap_q.sel0 == $past(sm_serial_clock_in)
      && strap_q.pol == $past(power_polarity_strap))
      else $error("straps not captured after reset release");
endmodule

/* bench/hspp_switch_model.sv */
// behavioural power switch with a current monitor for the port power block
`timescale 1ns/1ps
module hspp_switch_model
(
   // control from the hub
   input  wire logic port_power_enable,
   input  wire logic power_pol,
   // bench command: a shorted load on the downstream rail
   input  wire logic short_cmd,
   // report to the hub, open drain with pull-up
   output logic      overcurrent_sense_low
);
   logic trip = 1'b0;
   // trip holds until short_cmd drops, else cutting power would clear it and oscillate
   always @(port_power_enable, power_pol, short_cmd)
   begin
      if (!short_cmd)
         trip = 1'b0;
      else if (port_power_enable === power_pol)
         trip = 1'b1;
   end
   assign overcurrent_sense_low = trip ? 1'b0 : 1'b1;
endmodule

/* bench/hub_strap_port_power_ctrl_tb.sv */
// self-checking bench for strap capture and ganged port power
`timescale 1ns/1ps
module hub_strap_port_power_ctrl_tb;
   logic                ref_clk   = 1'b0;
   // low at time zero so that the first start gives reset a real rising edge
   logic                rst       = 1'b0;
   logic                pol_strap = 1'b1;
   logic [1:0]          fix_strap = 2'h0;
   logic                sel1      = 1'b1;
   logic                sel0      = 1'b0;
   logic                drv_low   = 1'b0;
   logic                pwr_req   = 1'b0;
   logic [1:0]          led_on    = 2'h0;
   logic                led_cfg   = 1'b0;
   logic                short_cmd = 1'b0;
   logic                exp_pol   = 1'b1;
   logic                sda_oe, sda_out, sda_in, eng_in, oc_n, ppe, oc_act;
   logic [1:0]          leds, nonrem;
   logic [6:0]          addr;
   hspp_pkg::hspp_cfg_e src;
   int                  err_count   = 0;
   int                  checks_done = 0;
   int                  cycles      = 0;

   // pin level: pull-up unless the block pulls low
   assign sda_in = sda_oe ? sda_out : 1'b1;

   hspp_port_power DUT (.ref_clk(ref_clk), .rst(rst),
      .power_polarity_strap(pol_strap), .fixed_port_strap(fix_strap),
      .config_select_bit1(sel1), .sm_serial_clock_in(sel0),
      .sm_serial_data_in(sda_in), .sm_serial_data_out(sda_out),
      .sm_serial_data_oe(sda_oe), .engine_data_drive_low(drv_low),
      .engine_data_in(eng_in), .overcurrent_sense_low(oc_n),
      .port_power_enable(ppe), .power_request(pwr_req),
      .led_led_on_req_unused(1'b0), .led_on(led_on),
      .led_support_cfg(led_cfg), .green_led_outputs(leds),
      .config_source(src), .smbus_slave_addr(addr),
      .non_removable(nonrem), .overcurrent_active(oc_act));

   hspp_switch_model PSW (.port_power_enable(ppe), .power_pol(exp_pol),
      .short_cmd(short_cmd), .overcurrent_sense_low(oc_n));

   initial
   begin
      forever #10 ref_clk = ~ref_clk;
   end

   task automatic conclude();
      $display("checks %0d mismatches %0d", checks_done, err_count);
      if (err_count == 0 && checks_done > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask

   // a hang costs one mismatch and ends the run
   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         err_count++;
         conclude();
      end
   end

   task automatic chk(input string what, input logic [7:0] seen, exp);
      checks_done++;
      if (seen !== exp)
      begin
         err_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask

   // reset with given straps, then turn the straps round once captured
   task automatic start(input logic p, input logic [1:0] f,
                        input logic s1, s0, input int hold);
      @(negedge ref_clk);
      rst = 1'b1;
      pwr_req = 1'b0;
      pol_strap = p;
      fix_strap = f;
      sel1 = s1;
      sel0 = s0;
      repeat (hold) @(negedge ref_clk);
      chk("enable in reset", 8'(ppe), 8'(!p));
      rst = 1'b0;
      exp_pol = p;
      repeat (2) @(negedge ref_clk);
      pol_strap = !p;
      fix_strap = ~f;
      sel1 = !s1;
      sel0 = !s0;
   endtask

   task automatic t_pol();
      for (int i = 0; i < 2; i++)
      begin
         start(i[0], 2'h0, 1'b1, 1'b0, 20);
         pwr_req = 1'b1;
         #1 chk("enable on", 8'(ppe), 8'(i[0]));
         @(negedge ref_clk);
         pwr_req = 1'b0;
         #1 chk("enable off", 8'(ppe), 8'(!i[0]));
      end
      $display("test pol done");
   endtask

   task automatic t_strap();
      logic [1:0] nr;
      for (int f = 0; f < 4; f++)
      begin
         led_on = 2'h2;
         start(1'b1, 2'(f), 1'b1, 1'b0, 2);
         nr = (f == 0) ? 2'h0 : (f == 1) ? 2'h1 : 2'h3;
         chk("source", 8'(src), 8'(hspp_pkg::HSPP_CFG_STRAP));
         chk("fixed", 8'(nonrem), 8'(nr));
         chk("leds", 8'(leds), 8'(2'h2 ^ 2'(f)));
      end
      $display("test strap done");
   endtask

   task automatic t_cfg();
      logic [1:0] sel [3] = '{2'h0, 2'h1, 2'h3};
      hspp_pkg::hspp_cfg_e ex [3] = '{hspp_pkg::HSPP_CFG_SMBUS,
         hspp_pkg::HSPP_CFG_SMBUS, hspp_pkg::HSPP_CFG_EEPROM};
      led_cfg = 1'b1;
      led_on = 2'h1;
      for (int i = 0; i < 3; i++)
      begin
         start(1'b1, 2'h3, sel[i][1], sel[i][0], 2);
         chk("source", 8'(src), 8'(ex[i]));
         chk("address", 8'(addr), 8'h2c);
         chk("fixed", 8'(nonrem), 8'h00);
         chk("leds", 8'(leds), 8'h02);
      end
      led_cfg = 1'b0;
      $display("test cfg done");
   endtask

   task automatic t_oc();
      start(1'b0, 2'h0, 1'b1, 1'b0, 2);
      pwr_req = 1'b1;
      short_cmd = 1'b1;
      @(negedge ref_clk);
      chk("enable before sync", 8'(ppe), 8'h00);
      repeat (3) @(negedge ref_clk);
      chk("enable cut", 8'(ppe), 8'h01);
      chk("oc flag", 8'(oc_act), 8'h01);
      short_cmd = 1'b0;
      repeat (4) @(negedge ref_clk);
      chk("enable back", 8'(ppe), 8'h00);
      chk("oc flag clear", 8'(oc_act), 8'h00);
      pwr_req = 1'b0;
      $display("test oc done");
   endtask

   task automatic t_sda();
      start(1'b1, 2'h0, 1'b1, 1'b1, 2);
      drv_low = 1'b1;
      #1 chk("pin low", 8'(eng_in), 8'h00);
      @(negedge ref_clk);
      drv_low = 1'b0;
      #1 chk("pin high", 8'(eng_in), 8'h01);
      $display("test sda done");
   endtask

   initial
   begin
      t_pol();
      t_strap();
      t_cfg();
      t_oc();
      t_sda();
      conclude();
   end
endmodule
